// ==== rtl/sfsr_pkg.sv ====
// Purpose: Shared constants and types for the suspend/resume parameter block
// Assumes: 50 MHz system clock, AXI4-Lite register access
// Notes: Parameter dword fields are packed most significant first

package sfsr_pkg;

  // ----------------------------------------------------------------------
  // Parameter dword layout
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       unsupported;
    logic [1:0] erase_lat_unit;
    logic [4:0] erase_lat_count;
    logic [3:0] erase_gap_count;
    logic [1:0] prog_lat_unit;
    logic [4:0] prog_lat_count;
    logic [3:0] prog_gap_count;
    logic       reserved_one;
    logic [3:0] erase_susp_ban;
    logic [3:0] prog_susp_ban;
  } sfsr_dw12_s;

  localparam logic [1:0] UNIT_128NS = 2'h0;
  localparam logic [1:0] UNIT_1US = 2'h1;
  localparam logic [1:0] UNIT_8US = 2'h2;
  localparam logic [1:0] UNIT_64US = 2'h3;

  localparam sfsr_dw12_s DW12_VALUE = '{
    unsupported: 1'h0,
    erase_lat_unit: UNIT_1US,
    erase_lat_count: 5'h13,
    erase_gap_count: 4'h1,
    prog_lat_unit: UNIT_1US,
    prog_lat_count: 5'h13,
    prog_gap_count: 4'h1,
    reserved_one: 1'h1,
    erase_susp_ban: 4'hc,
    prog_susp_ban: 4'hc
  };

  // Relative byte addresses of the dword inside the parameter table
  localparam logic [7:0] SFDP_DW12_BYTE0 = 8'h2c;
  localparam logic [7:0] SFDP_DW12_BYTE3 = 8'h2f;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SEL = 8'h08;
  localparam logic [7:0] REG_BYTE = 8'h0c;
  localparam logic [7:0] REG_PARAM = 8'h2c;

  // Control bits (write one to act)
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_SUSPEND = 2;
  localparam int CTRL_RESUME = 3;

  // Status bits
  localparam int ST_ERASE_RUN = 0;
  localparam int ST_PROG_RUN = 1;
  localparam int ST_HALTING = 2;
  localparam int ST_ERASE_SUSP = 3;
  localparam int ST_PROG_SUSP = 4;
  localparam int ST_GAP_OPEN = 5;
  localparam int ST_ERR_EARLY = 8;
  localparam int ST_ERR_BANNED = 9;
  localparam int ST_DONE = 10;

  localparam logic [7:0] SEL_RESET = 8'h2c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SUSPEND_LATENCY_NS = 20000;
  localparam int RESUME_GAP_NS = 128000;
  // Longest time rounds down, least time rounds up
  localparam int SUSPEND_LATENCY_CYCLES = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
  localparam int RESUME_GAP_CYCLES = (RESUME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALT_CYCLES_DEFAULT = 16;
  localparam int OP_CYCLES_DEFAULT = 50000;
  localparam int TIMER_W = 16;

  typedef enum {
    OP_IDLE,
    OP_ERASE,
    OP_PROG,
    OP_HALT,
    OP_ERASE_SUSP,
    OP_PROG_SUSP
  } sfsr_op_e;

endpackage

// ==== rtl/sfsr_timer.sv ====
// Purpose: Loadable down counter used for operation time and suspend timing
// Assumes: Single clock, synchronised active-low reset
// Notes: Holds its value while run is low, so a suspended operation keeps its remainder

`timescale 1ns/1ps

module sfsr_timer
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [sfsr_pkg::TIMER_W-1:0] i_value,
  input wire logic i_run,
  output logic o_zero
);

  logic [sfsr_pkg::TIMER_W-1:0] count_q;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_q <= '0;
    end
    else if (i_load)
    begin
      count_q <= i_value;
    end
    else if (i_run && (count_q != '0))
    begin
      count_q <= count_q - 1'b1;
    end
  end

  assign o_zero = (count_q == '0);

endmodule

// ==== rtl/sfsr_top.sv ====
// Purpose: Suspend/resume parameter dword and a suspendable erase/program sequencer
// Assumes: 50 MHz clock, AXI4-Lite master, host keeps its own suspend timing duties
// Notes: Early or banned host requests are refused and flagged in status

`timescale 1ns/1ps

module sfsr_top
#(
  parameter int RESUME_GAP = sfsr_pkg::RESUME_GAP_CYCLES,
  parameter int HALT_CYCLES = sfsr_pkg::HALT_CYCLES_DEFAULT,
  parameter int OP_CYCLES = sfsr_pkg::OP_CYCLES_DEFAULT
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Parameter table lookup
  // ----------------------------------------------------------------------
  localparam logic [31:0] DW12 = sfsr_pkg::DW12_VALUE;

  // Bytes outside the dword read zero
  function automatic logic [7:0] sfdp_byte(input logic [7:0] addr);
    sfdp_byte = ((addr < sfsr_pkg::SFDP_DW12_BYTE0) || (addr > sfsr_pkg::SFDP_DW12_BYTE3)) ?
      8'h00 : DW12[{addr[1:0], 3'h0} +: 8];
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_mapped;

  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_mapped = (awaddr_q == sfsr_pkg::REG_CTRL) || (awaddr_q == sfsr_pkg::REG_STATUS)
    || (awaddr_q == sfsr_pkg::REG_SEL) || (awaddr_q == sfsr_pkg::REG_BYTE)
    || (awaddr_q == sfsr_pkg::REG_PARAM);

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (o_awready && i_awvalid)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= {i_awaddr[7:2], 2'h0};
    end
    else if (wr_fire)
    begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (o_wready && i_wvalid)
    begin
      w_held_q <= 1'b1;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end
    else if (wr_fire)
    begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= sfsr_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? sfsr_pkg::RESP_OKAY : sfsr_pkg::RESP_SLVERR;
    end
    else if (i_bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Decoded write pulses, low byte lane carries the commands
  logic cmd_wr;
  logic clr_wr;
  logic [3:0] cmd;
  logic [2:0] clr;

  assign cmd_wr = wr_fire && (awaddr_q == sfsr_pkg::REG_CTRL) && wstrb_q[0];
  assign clr_wr = wr_fire && (awaddr_q == sfsr_pkg::REG_STATUS) && wstrb_q[1];
  assign cmd = cmd_wr ? wdata_q[3:0] : 4'h0;
  assign clr = clr_wr ? wdata_q[10:8] : 3'h0;

  logic [7:0] sel_q;

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sel_q <= sfsr_pkg::SEL_RESET;
    end
    else if (wr_fire && (awaddr_q == sfsr_pkg::REG_SEL) && wstrb_q[0])
    begin
      sel_q <= wdata_q[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Erase / program sequencer
  // ----------------------------------------------------------------------
  sfsr_pkg::sfsr_op_e op_q;
  logic halt_erase_q;
  logic op_zero;
  logic aux_zero;
  logic op_load;
  logic aux_load;
  logic [sfsr_pkg::TIMER_W-1:0] aux_value;
  logic start_op;
  logic susp_ok;
  logic susp_early;
  logic banned;
  logic resume;

  localparam logic [sfsr_pkg::TIMER_W-1:0] OP_LEN = sfsr_pkg::TIMER_W'(OP_CYCLES);
  localparam logic [sfsr_pkg::TIMER_W-1:0] GAP_LEN = sfsr_pkg::TIMER_W'(RESUME_GAP);
  // Halt delay is capped at the advertised latency; at the cap the halt lasts one cycle past the reported figure
  localparam logic [sfsr_pkg::TIMER_W-1:0] HALT_LEN = sfsr_pkg::TIMER_W'(
    (HALT_CYCLES > sfsr_pkg::SUSPEND_LATENCY_CYCLES) ?
    sfsr_pkg::SUSPEND_LATENCY_CYCLES : HALT_CYCLES);

  assign start_op = (op_q == sfsr_pkg::OP_IDLE) && (cmd[sfsr_pkg::CTRL_ERASE]
    || cmd[sfsr_pkg::CTRL_PROG]);
  assign susp_ok = ((op_q == sfsr_pkg::OP_ERASE) || (op_q == sfsr_pkg::OP_PROG)) && !op_zero
    && cmd[sfsr_pkg::CTRL_SUSPEND] && aux_zero;
  // The resume gap is the host's duty; a suspend inside it is refused
  assign susp_early = ((op_q == sfsr_pkg::OP_ERASE) || (op_q == sfsr_pkg::OP_PROG)) && !op_zero
    && cmd[sfsr_pkg::CTRL_SUSPEND] && !aux_zero;
  // No erase or page program may start while anything is suspended
  assign banned = ((op_q == sfsr_pkg::OP_ERASE_SUSP) || (op_q == sfsr_pkg::OP_PROG_SUSP))
    && (cmd[sfsr_pkg::CTRL_ERASE] || cmd[sfsr_pkg::CTRL_PROG]);
  assign resume = ((op_q == sfsr_pkg::OP_ERASE_SUSP) || (op_q == sfsr_pkg::OP_PROG_SUSP))
    && cmd[sfsr_pkg::CTRL_RESUME];

  assign op_load = start_op;
  assign aux_load = start_op || susp_ok || resume;
  assign aux_value = start_op ? '0 : (susp_ok ? HALT_LEN : GAP_LEN);

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      op_q <= sfsr_pkg::OP_IDLE;
      halt_erase_q <= 1'b0;
    end
    else
    begin
      unique case (op_q)
        sfsr_pkg::OP_IDLE:
        begin
          if (start_op)
          begin
            op_q <= cmd[sfsr_pkg::CTRL_ERASE] ? sfsr_pkg::OP_ERASE : sfsr_pkg::OP_PROG;
          end
        end
        sfsr_pkg::OP_ERASE, sfsr_pkg::OP_PROG:
        begin
          if (op_zero)
          begin
            op_q <= sfsr_pkg::OP_IDLE;
          end
          else if (susp_ok)
          begin
            op_q <= sfsr_pkg::OP_HALT;
            halt_erase_q <= (op_q == sfsr_pkg::OP_ERASE);
          end
        end
        sfsr_pkg::OP_HALT:
        begin
          // Halt ends HALT_LEN+1 cycles after the request is taken, within the advertised latency only while HALT_LEN is below the cap
          if (aux_zero)
          begin
            op_q <= halt_erase_q ? sfsr_pkg::OP_ERASE_SUSP : sfsr_pkg::OP_PROG_SUSP;
          end
        end
        sfsr_pkg::OP_ERASE_SUSP, sfsr_pkg::OP_PROG_SUSP:
        begin
          if (resume)
          begin
            op_q <= (op_q == sfsr_pkg::OP_ERASE_SUSP) ? sfsr_pkg::OP_ERASE : sfsr_pkg::OP_PROG;
          end
        end
      endcase
    end
  end

  sfsr_timer u_op_timer
  (
    .i_clock(i_clock),
    .i_rst_n(rst_n_q),
    .i_load(op_load),
    .i_value(OP_LEN),
    .i_run((op_q == sfsr_pkg::OP_ERASE) || (op_q == sfsr_pkg::OP_PROG)),
    .o_zero(op_zero)
  );

  sfsr_timer u_aux_timer
  (
    .i_clock(i_clock),
    .i_rst_n(rst_n_q),
    .i_load(aux_load),
    .i_value(aux_value),
    .i_run(1'b1),
    .o_zero(aux_zero)
  );

  // ----------------------------------------------------------------------
  // Sticky status flags, a new event wins over a clear
  // ----------------------------------------------------------------------
  logic err_early_q;
  logic err_banned_q;
  logic done_q;
  logic op_done;

  assign op_done = ((op_q == sfsr_pkg::OP_ERASE) || (op_q == sfsr_pkg::OP_PROG)) && op_zero;

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      err_early_q <= 1'b0;
      err_banned_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      err_early_q <= susp_early || (err_early_q && !clr[0]);
      err_banned_q <= banned || (err_banned_q && !clr[1]);
      done_q <= op_done || (done_q && !clr[2]);
    end
  end

  logic [31:0] status;

  always_comb
  begin
    status = '0;
    status[sfsr_pkg::ST_ERASE_RUN] = (op_q == sfsr_pkg::OP_ERASE);
    status[sfsr_pkg::ST_PROG_RUN] = (op_q == sfsr_pkg::OP_PROG);
    status[sfsr_pkg::ST_HALTING] = (op_q == sfsr_pkg::OP_HALT);
    status[sfsr_pkg::ST_ERASE_SUSP] = (op_q == sfsr_pkg::OP_ERASE_SUSP);
    status[sfsr_pkg::ST_PROG_SUSP] = (op_q == sfsr_pkg::OP_PROG_SUSP);
    status[sfsr_pkg::ST_GAP_OPEN] = !aux_zero && (op_q != sfsr_pkg::OP_HALT);
    status[sfsr_pkg::ST_ERR_EARLY] = err_early_q;
    status[sfsr_pkg::ST_ERR_BANNED] = err_banned_q;
    status[sfsr_pkg::ST_DONE] = done_q;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] raddr;

  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign raddr = {i_araddr[7:2], 2'h0};

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= sfsr_pkg::RESP_OKAY;
    end
    else if (i_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= sfsr_pkg::RESP_OKAY;
      unique case (raddr)
        sfsr_pkg::REG_CTRL: rdata_q <= '0;
        sfsr_pkg::REG_STATUS: rdata_q <= status;
        sfsr_pkg::REG_SEL: rdata_q <= {24'h0, sel_q};
        sfsr_pkg::REG_BYTE: rdata_q <= {24'h0, sfdp_byte(sel_q)};
        sfsr_pkg::REG_PARAM: rdata_q <= DW12;
        default:
        begin
          rdata_q <= '0;
          rresp_q <= sfsr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (i_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ==== verification/sfsr_checker.sv ====
// Purpose: Port level checks of the parameter dword and bus handshakes
// Assumes: Param word is read at REG_PARAM, answer one cycle after the address
// Notes: Bound to every sfsr_top instance

`timescale 1ns/1ps

module sfsr_checker
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp
);
  logic param_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // Remembers that the read now standing was aimed at the param word
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      param_q <= 1'b0;
    else if (i_arvalid && o_arready)
      param_q <= (i_araddr[7:2] == sfsr_pkg::REG_PARAM[7:2]);
  end

  // ----------------------------------------------------------------------
  // Dword fields
  // ----------------------------------------------------------------------
  support_flag_a: assert property (o_rvalid && param_q
    |-> !o_rdata[31] && o_rdata[7:0] == 8'hcc) else $error("support field wrong");
  erase_unit_a: assert property (o_rvalid && param_q
    |-> o_rdata[30:29] == 2'h1) else $error("erase unit wrong");
  erase_count_a: assert property (o_rvalid && param_q
    |-> o_rdata[28:24] == 5'h13) else $error("erase count wrong");
  erase_gap_a: assert property (o_rvalid && param_q
    |-> o_rdata[23:20] == 4'h1) else $error("erase gap wrong");
  prog_latency_a: assert property (o_rvalid && param_q
    |-> o_rdata[19:13] == 7'h33) else $error("program latency wrong");
  prog_gap_a: assert property (o_rvalid && param_q
    |-> o_rdata[12:9] == 4'h1) else $error("program gap wrong");
  reserved_one_a: assert property (o_rvalid && param_q
    |-> o_rdata[8]) else $error("reserved bit wrong");
  suspend_bans_a: assert property (o_rvalid && param_q
    |-> o_rdata[7:4] == 4'hc && o_rdata[3:0] == 4'hc) else $error("ban fields wrong");
  param_word_a: assert property (i_arvalid && o_arready && i_araddr == 8'h2c
    |=> o_rvalid && o_rdata == 32'h331663cc) else $error("param word wrong");

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  read_hold_a: assert property (o_rvalid && !i_rready
    |=> o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  write_hold_a: assert property (o_bvalid && !i_bready
    |=> o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  read_answer_a: assert property (i_arvalid && o_arready
    |=> o_rvalid) else $error("read not answered");
  read_release_a: assert property (o_rvalid && i_rready
    |=> !o_rvalid) else $error("read answer not released");
  write_release_a: assert property (o_bvalid && i_bready
    |=> !o_bvalid) else $error("write response not released");
endmodule

bind sfsr_top sfsr_checker i_checker
(
  .i_clock(i_clock), .i_rstn(i_rstn), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp)
);

// ==== verification/sfsr_host_model.sv ====
// Purpose: Bus master standing in for the host that reads parameters and suspends
// Assumes: Ready and response sampled just after an edge, acted on at the next edge
// Notes: Released address and data lines show the inverse of the last value

`timescale 1ns/1ps

module sfsr_host_model
(
  input wire logic i_clock,
  output logic o_awvalid,
  output logic [7:0] o_awaddr,
  output logic o_wvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_bready,
  output logic o_arvalid,
  output logic [7:0] o_araddr,
  output logic o_rready,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic [1:0] i_bresp,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp
);
  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h0;
    {o_awaddr, o_araddr, o_wdata, o_wstrb} = 52'h0;
  end

  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    logic tb;
    @(posedge i_clock);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= 4'hf;
    o_bready <= 1'b1;
    forever
    begin
      #1;
      ta = o_awvalid && i_awready;
      tw = o_wvalid && i_wready;
      tb = i_bvalid;
      r = i_bresp;
      @(posedge i_clock);
      if (ta) o_awvalid <= 1'b0;
      if (ta) o_awaddr <= ~a;
      if (tw) o_wvalid <= 1'b0;
      if (tw) o_wdata <= ~d;
      o_bready <= !tb;
      if (tb) break;
    end
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tr;
    @(posedge i_clock);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    forever
    begin
      #1;
      ta = o_arvalid && i_arready;
      tr = i_rvalid;
      d = i_rdata;
      r = i_rresp;
      @(posedge i_clock);
      if (ta) o_arvalid <= 1'b0;
      if (ta) o_araddr <= ~a;
      o_rready <= !tr;
      if (tr) break;
    end
  endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the parameter dword and the suspend sequencer
// Assumes: Short operation and gap counts set by parameters
// Notes: Host duties are broken on purpose to see the refusals

`timescale 1ns/1ps

module testbench;
  logic clock;
  logic rstn;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_checks = 0;
  int miscompares = 0;
  int cyc = 0;

  sfsr_top #(.RESUME_GAP(20), .HALT_CYCLES(16), .OP_CYCLES(200)) i_dut
  (
    .i_clock(clock), .i_rstn(rstn), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp)
  );

  sfsr_host_model i_host
  (
    .i_clock(clock), .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready), .o_arvalid(arvalid),
    .o_araddr(araddr), .o_rready(rready), .i_awready(awready), .i_wready(wready),
    .i_bvalid(bvalid), .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
    .i_rdata(rdata), .i_rresp(rresp)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) cyc <= cyc + 1;

  // ----------------------------------------------------------------------
  // Checking and access tasks
  // ----------------------------------------------------------------------
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t data got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_host.write(a, d, r);
    cmp_resp(r, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_host.read(a, d, r);
    cmp_resp(r, er);
    cmp_data(d & m, e);
  endtask

  // Polls a status bit; a poll that runs past the limit with the bit still low counts a mismatch
  task automatic poll(input int b, input int lim);
    logic [31:0] d;
    logic [1:0] r;
    int t0;
    t0 = cyc;
    do i_host.read(sfsr_pkg::REG_STATUS, d, r);
    while (d[b] !== 1'b1 && cyc - t0 < lim);
    cmp_data({31'h0, d[b]}, 32'h1);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    final_report;
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    logic [7:0] bytes [5];
    logic [31:0] one;
    bytes = '{8'hcc, 8'h63, 8'h16, 8'h33, 8'h00};
    rstn = 1'b0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(sfsr_pkg::REG_PARAM, 32'hffffffff, 32'h331663cc, 2'h0);
    wr(sfsr_pkg::REG_PARAM, 32'h0, 2'h0);
    rd(sfsr_pkg::REG_PARAM, 32'hffffffff, 32'h331663cc, 2'h0);
    rd(sfsr_pkg::REG_SEL, 32'hff, 32'h2c, 2'h0);
    rd(sfsr_pkg::REG_CTRL, 32'hffffffff, 32'h0, 2'h0);
    for (int i = 0; i < 5; i++)
    begin
      wr(sfsr_pkg::REG_SEL, 32'h2c + i, 2'h0);
      rd(sfsr_pkg::REG_BYTE, 32'hff, {24'h0, bytes[i]}, 2'h0);
    end
    rd(8'hf0, 32'hffffffff, 32'h0, sfsr_pkg::RESP_SLVERR);
    wr(8'hf0, 32'h0, sfsr_pkg::RESP_SLVERR);
    for (int op = 0; op < 2; op++)
    begin
      one = 32'h1 << op;
      wr(sfsr_pkg::REG_CTRL, one, 2'h0);
      rd(sfsr_pkg::REG_STATUS, 32'h1f, one, 2'h0);
      wr(sfsr_pkg::REG_CTRL, 32'h4, 2'h0);
      rd(sfsr_pkg::REG_STATUS, 32'h1f, 32'h4, 2'h0);
      poll(sfsr_pkg::ST_ERASE_SUSP + op, 1000);
      wr(sfsr_pkg::REG_CTRL, 32'h3, 2'h0);
      rd(sfsr_pkg::REG_STATUS, 32'h21f, 32'h200 | (one << 3), 2'h0);
      wr(sfsr_pkg::REG_CTRL, 32'h8, 2'h0);
      wr(sfsr_pkg::REG_CTRL, 32'h4, 2'h0);
      rd(sfsr_pkg::REG_STATUS, 32'h13f, 32'h120 | one, 2'h0);
      wr(sfsr_pkg::REG_STATUS, 32'h700, 2'h0);
      poll(sfsr_pkg::ST_DONE, 2000);
      rd(sfsr_pkg::REG_STATUS, 32'h71f, 32'h400, 2'h0);
      wr(sfsr_pkg::REG_STATUS, 32'h700, 2'h0);
    end
    final_report;
  end
endmodule
